// ===== flag_pkg.sv
// Constants, read commands, flag bit positions and carrier types for the fault flag store.
// Assumes a 50 MHz reference clock and condition inputs already synchronous to it.
//
// Contract
// RULE1: First LIN flag byte: wake 6, term short 5, hot 4, rx low 3, rx high 2, tx 1, clamp 0.
// RULE2: Second LIN flag byte uses the same layout, bit 7 zero, own read command.
// RULE3: First LIN live read returns transceiver state bit 7, wake receiver enable bit 6.
// RULE4: Second LIN live read returns transceiver state bit 7, wake enable bit 6.
// RULE5: Aux regulator overload flag sets after over 100 us; clears when gone and read.
// RULE6: Aux regulator under flag sets after over 100 us low; clears when recovered and read.
// RULE7: Bus supply hot flag sets while hot; clears when cool and read.
// RULE8: Bus supply under flag sets after over 100 us low; clears when recovered and read.
// RULE9: Bus supply overload flag sets after over 100 us; clears when gone and read.
// RULE10: Sense input low flag sets after over 100 us low; clears when recovered and read.
// RULE11: Battery under flag sets after over 100 us low; clears when recovered and read.
// RULE12: Main overload flag sets in normal mode after over 100 us; clears when gone, read.
// RULE13: Low-power overload flag sets in low-power regulator-on mode after 100 us.
// RULE14: Main hot-off flag sets on thermal shutdown; clears after recovery and read.
// RULE15: Short reset flag sets on reset pin low pulse under 100 ms; clears after end, read.
// RULE16: Battery fail flag sets below fail level; clears when above and read.
// RULE17: A read during a still-present fault leaves the flag set.
// RULE18: Live status bits follow hardware directly and reads never alter them.

package flag_pkg;

  // Read commands as seen on the serial command word.
  localparam logic [15:0] CMD_REG_FLAGS_LO = 16'hDF00;
  localparam logic [15:0] CMD_REG_FLAGS_HI = 16'hDF80;
  localparam logic [15:0] CMD_LIN1_FLAGS   = 16'hE700;
  localparam logic [15:0] CMD_LIN1_LIVE    = 16'h2780;
  localparam logic [15:0] CMD_LIN2_FLAGS   = 16'hE900;
  localparam logic [15:0] CMD_LIN2_LIVE    = 16'h2980;
  localparam logic [7:0]  RESP_UNMAPPED    = 8'h00;

  // Timing.
  localparam int CLK_PERIOD_NS     = 20;
  localparam int FILTER_TIME_NS    = 100000;
  localparam int FILTER_CYCLES     = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_RST_TIME_NS = 100000000;
  localparam int SHORT_RST_CYCLES  = SHORT_RST_TIME_NS / CLK_PERIOD_NS;

  // Live status byte positions.
  localparam int LIVE_STATE_BIT   = 7;
  localparam int LIVE_WAKE_EN_BIT = 6;

  // Low regulator flag byte positions.
  localparam int LO_AUX_UNDER_BIT     = 7;
  localparam int LO_AUX_OVERLOAD_BIT  = 6;
  localparam int LO_BUS_HOT_BIT       = 5;
  localparam int LO_BUS_UNDER_BIT     = 4;
  localparam int LO_BUS_OVERLOAD_BIT  = 3;
  localparam int LO_SENSE_LOW_BIT     = 2;
  localparam int LO_BATTERY_UNDER_BIT = 1;
  localparam int LO_MAIN_OVERLOAD_BIT = 0;

  // High regulator flag byte positions.
  localparam int HI_MAIN_HOT_OFF_BIT  = 4;
  localparam int HI_RESET_SHORT_BIT   = 2;
  localparam int HI_BATTERY_FAIL_BIT  = 1;
  localparam int HI_LP_OVERLOAD_BIT   = 0;

  // Filtered flag slots.
  localparam int NUM_FILTERED   = 8;
  localparam int F_AUX_UNDER    = 7;
  localparam int F_AUX_OVERLOAD = 6;
  localparam int F_BUS_UNDER    = 5;
  localparam int F_BUS_OVERLOAD = 4;
  localparam int F_SENSE_LOW    = 3;
  localparam int F_BATT_UNDER   = 2;
  localparam int F_MAIN_OVLD    = 1;
  localparam int F_LP_OVLD      = 0;

  // Unfiltered flag slots.
  localparam int NUM_DIRECT     = 4;
  localparam int D_BUS_HOT      = 3;
  localparam int D_MAIN_HOT_OFF = 2;
  localparam int D_BATT_FAIL    = 1;
  localparam int D_RESET_SHORT  = 0;

  localparam int LIN_FLAG_BITS = 7;

  // Field order matches the flag byte, so the struct maps straight onto bits 6..0.
  typedef struct packed {
    logic wake;
    logic term_short;
    logic over_temp;
    logic rx_low;
    logic rx_high;
    logic tx_dominant;
    logic bus_clamp;
  } lin_cond_t;

  typedef struct packed {
    logic aux_low;
    logic aux_overcurrent;
    logic bus_overtemp;
    logic bus_low;
    logic bus_overcurrent;
    logic sense_low;
    logic battery_low;
    logic main_overcurrent;
    logic main_thermal_off;
    logic battery_below_fail;
    logic lowpower_overcurrent;
  } supply_cond_t;

  typedef enum {
    SEL_NONE,
    SEL_REG_LO,
    SEL_REG_HI,
    SEL_LIN1_FLAGS,
    SEL_LIN1_LIVE,
    SEL_LIN2_FLAGS,
    SEL_LIN2_LIVE
  } read_sel_t;

endpackage

// ===== fault_filter.sv
// Qualifies a fault condition that must persist longer than a set number of cycles.
// Assumes the condition input is synchronous to ref_clk_in.
`timescale 1ns/1ns

module fault_filter
  import flag_pkg::*;
#(
  parameter int CYCLES = FILTER_CYCLES
)
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Condition
  input  wire logic cond_in,
  output logic      qualified_out
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // Any gap in the condition restarts the count, so glitches never accumulate.
  assign next_count    = !cond_in ? '0 : (count == LIMIT) ? count : count + 1'b1;
  assign qualified_out = cond_in && (count == LIMIT);

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      count <= '0;
    else
      count <= next_count;
  end

  chk_filter_restart: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !cond_in |=> !qualified_out) else $error("filter qualified without a held condition");

endmodule

// ===== sticky_flag.sv
// One sticky fault flag: set by an event, cleared by a read only once the fault has gone.
// Assumes set, active and clear are synchronous to ref_clk_in.
`timescale 1ns/1ns

module sticky_flag
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Flag control
  input  wire logic set_in,
  input  wire logic active_in,
  input  wire logic clear_in,
  output logic      flag_out
);

  logic next_flag;

  // A set in the clear cycle wins, and a fault still present blocks the clear.
  assign next_flag = set_in || (flag_out && !(clear_in && !active_in)); // RULE17

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      flag_out <= 1'b0;
    else
      flag_out <= next_flag;
  end

  chk_flag_keep: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    flag_out && active_in |=> flag_out) else $error("flag lost while fault present"); // RULE17

endmodule

// ===== supply_and_lin_fault_flags.sv
// Fault flag store for regulator, supply, reset pin and two LIN channels, read by command.
// Assumes all condition inputs and the command strobe are synchronous to ref_clk_in.
`timescale 1ns/1ns

module supply_and_lin_fault_flags
  import flag_pkg::*;
#(
  parameter int FILTER_CYCLES_P    = FILTER_CYCLES,
  parameter int SHORT_RST_CYCLES_P = SHORT_RST_CYCLES
)
(
  // Clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  // Supply and regulator fault conditions
  input  wire supply_cond_t supply_cond_in,
  input  wire logic         normal_mode_in,
  input  wire logic         lowpower_vdd_on_in,
  input  wire logic         reset_pin_n_in,
  // LIN channel conditions and live state
  input  wire lin_cond_t    lin_one_cond_in,
  input  wire lin_cond_t    lin_two_cond_in,
  input  wire logic         lin_one_state_in,
  input  wire logic         lin_one_wake_receiver_enable_in,
  input  wire logic         lin_two_state_in,
  input  wire logic         lin_two_wake_receiver_enable_in,
  // Command and response
  input  wire logic         cmd_valid_in,
  input  wire logic [15:0]  cmd_in,
  output logic              resp_valid_out,
  output logic [7:0]        resp_data_out
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Command decode

  function automatic read_sel_t decode_cmd(input logic [15:0] cmd);
    read_sel_t sel;
    sel = SEL_NONE;
    if (cmd == CMD_REG_FLAGS_LO)
      sel = SEL_REG_LO;
    else if (cmd == CMD_REG_FLAGS_HI)
      sel = SEL_REG_HI;
    else if (cmd == CMD_LIN1_FLAGS)
      sel = SEL_LIN1_FLAGS;
    else if (cmd == CMD_LIN1_LIVE)
      sel = SEL_LIN1_LIVE;
    else if (cmd == CMD_LIN2_FLAGS)
      sel = SEL_LIN2_FLAGS;
    else if (cmd == CMD_LIN2_LIVE)
      sel = SEL_LIN2_LIVE;
    return sel;
  endfunction

  read_sel_t sel;
  logic      clr_reg_lo;
  logic      clr_reg_hi;
  logic      clr_lin_one;
  logic      clr_lin_two;

  assign sel         = cmd_valid_in ? decode_cmd(cmd_in) : SEL_NONE;
  assign clr_reg_lo  = (sel == SEL_REG_LO);
  assign clr_reg_hi  = (sel == SEL_REG_HI);
  assign clr_lin_one = (sel == SEL_LIN1_FLAGS);
  assign clr_lin_two = (sel == SEL_LIN2_FLAGS);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Filtered supply flags

  logic [NUM_FILTERED-1:0] filt_raw;
  logic [NUM_FILTERED-1:0] filt_active;
  logic [NUM_FILTERED-1:0] filt_clear;
  logic [NUM_FILTERED-1:0] filt_set;
  logic [NUM_FILTERED-1:0] filt_flag;

  // The main and low-power overcurrent faults only count in their own mode, but either overcurrent blocks its clear in any mode.
  assign filt_raw[F_AUX_UNDER]    = supply_cond_in.aux_low;                        // RULE6
  assign filt_raw[F_AUX_OVERLOAD] = supply_cond_in.aux_overcurrent;                // RULE5
  assign filt_raw[F_BUS_UNDER]    = supply_cond_in.bus_low;                        // RULE8
  assign filt_raw[F_BUS_OVERLOAD] = supply_cond_in.bus_overcurrent;                // RULE9
  assign filt_raw[F_SENSE_LOW]    = supply_cond_in.sense_low;                      // RULE10
  assign filt_raw[F_BATT_UNDER]   = supply_cond_in.battery_low;                    // RULE11
  assign filt_raw[F_MAIN_OVLD]    = supply_cond_in.main_overcurrent && normal_mode_in; // RULE12
  assign filt_raw[F_LP_OVLD]      = supply_cond_in.lowpower_overcurrent
                                    && lowpower_vdd_on_in;                         // RULE13

  localparam logic [NUM_FILTERED-1:0] HI_SLOT = NUM_FILTERED'(1) << F_LP_OVLD;

  assign filt_active = filt_raw
                       | (NUM_FILTERED'(supply_cond_in.main_overcurrent) << F_MAIN_OVLD) // RULE12
                       | (NUM_FILTERED'(supply_cond_in.lowpower_overcurrent) << F_LP_OVLD); // RULE13
  assign filt_clear  = ({NUM_FILTERED{clr_reg_lo}} & ~HI_SLOT)
                       | ({NUM_FILTERED{clr_reg_hi}} & HI_SLOT);

  generate
    for (genvar i = 0; i < NUM_FILTERED; i++)
    begin : g_filt
      fault_filter #(.CYCLES(FILTER_CYCLES_P)) u_filter (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .cond_in       (filt_raw[i]),
        .qualified_out (filt_set[i])
      );
      sticky_flag u_flag (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .set_in     (filt_set[i]),
        .active_in  (filt_active[i]),
        .clear_in   (filt_clear[i]),
        .flag_out   (filt_flag[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset pin short pulse detector

  localparam int RW = $clog2(SHORT_RST_CYCLES_P + 1);
  localparam logic [RW-1:0] RST_LIMIT = RW'(SHORT_RST_CYCLES_P);

  logic [RW-1:0] low_count;
  logic [RW-1:0] next_low_count;
  logic          pin_prev;
  logic          short_event;

  // The count saturates, so a long hold never wraps around into a false short pulse.
  assign next_low_count = reset_pin_n_in ? '0 :
                          (low_count == RST_LIMIT) ? low_count : low_count + 1'b1;
  assign short_event    = reset_pin_n_in && !pin_prev && (low_count < RST_LIMIT); // RULE15

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      low_count <= '0;
      pin_prev  <= 1'b1;
    end
    else
    begin
      low_count <= next_low_count;
      pin_prev  <= reset_pin_n_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Unfiltered supply flags

  logic [NUM_DIRECT-1:0] dir_set;
  logic [NUM_DIRECT-1:0] dir_active;
  logic [NUM_DIRECT-1:0] dir_clear;
  logic [NUM_DIRECT-1:0] dir_flag;

  assign dir_set[D_BUS_HOT]         = supply_cond_in.bus_overtemp;       // RULE7
  assign dir_set[D_MAIN_HOT_OFF]    = supply_cond_in.main_thermal_off;   // RULE14
  assign dir_set[D_BATT_FAIL]       = supply_cond_in.battery_below_fail; // RULE16
  assign dir_set[D_RESET_SHORT]     = short_event;                       // RULE15
  assign dir_active[D_BUS_HOT]      = supply_cond_in.bus_overtemp;
  assign dir_active[D_MAIN_HOT_OFF] = supply_cond_in.main_thermal_off;
  assign dir_active[D_BATT_FAIL]    = supply_cond_in.battery_below_fail;
  assign dir_active[D_RESET_SHORT]  = !reset_pin_n_in;
  assign dir_clear[D_BUS_HOT]       = clr_reg_lo;
  assign dir_clear[D_MAIN_HOT_OFF]  = clr_reg_hi;
  assign dir_clear[D_BATT_FAIL]     = clr_reg_hi;
  assign dir_clear[D_RESET_SHORT]   = clr_reg_hi;

  generate
    for (genvar i = 0; i < NUM_DIRECT; i++)
    begin : g_dir
      sticky_flag u_flag (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .set_in     (dir_set[i]),
        .active_in  (dir_active[i]),
        .clear_in   (dir_clear[i]),
        .flag_out   (dir_flag[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // LIN channel flags

  logic [LIN_FLAG_BITS-1:0] lin_one_flags;
  logic [LIN_FLAG_BITS-1:0] lin_two_flags;

  generate
    for (genvar i = 0; i < LIN_FLAG_BITS; i++)
    begin : g_lin
      sticky_flag u_one (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .set_in     (lin_one_cond_in[i]),
        .active_in  (lin_one_cond_in[i]),
        .clear_in   (clr_lin_one),
        .flag_out   (lin_one_flags[i])
      );
      sticky_flag u_two (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .set_in     (lin_two_cond_in[i]),
        .active_in  (lin_two_cond_in[i]),
        .clear_in   (clr_lin_two),
        .flag_out   (lin_two_flags[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Response assembly

  logic [7:0] reg_lo_byte;
  logic [7:0] reg_hi_byte;
  logic [7:0] lin_one_live;
  logic [7:0] lin_two_live;
  logic [7:0] next_resp;

  always_comb
  begin
    reg_lo_byte                       = '0;
    reg_lo_byte[LO_AUX_UNDER_BIT]     = filt_flag[F_AUX_UNDER];
    reg_lo_byte[LO_AUX_OVERLOAD_BIT]  = filt_flag[F_AUX_OVERLOAD];
    reg_lo_byte[LO_BUS_HOT_BIT]       = dir_flag[D_BUS_HOT];
    reg_lo_byte[LO_BUS_UNDER_BIT]     = filt_flag[F_BUS_UNDER];
    reg_lo_byte[LO_BUS_OVERLOAD_BIT]  = filt_flag[F_BUS_OVERLOAD];
    reg_lo_byte[LO_SENSE_LOW_BIT]     = filt_flag[F_SENSE_LOW];
    reg_lo_byte[LO_BATTERY_UNDER_BIT] = filt_flag[F_BATT_UNDER];
    reg_lo_byte[LO_MAIN_OVERLOAD_BIT] = filt_flag[F_MAIN_OVLD];
    reg_hi_byte                       = '0;
    reg_hi_byte[HI_MAIN_HOT_OFF_BIT]  = dir_flag[D_MAIN_HOT_OFF];
    reg_hi_byte[HI_RESET_SHORT_BIT]   = dir_flag[D_RESET_SHORT];
    reg_hi_byte[HI_BATTERY_FAIL_BIT]  = dir_flag[D_BATT_FAIL];
    reg_hi_byte[HI_LP_OVERLOAD_BIT]   = filt_flag[F_LP_OVLD];
    lin_one_live                      = '0;
    lin_one_live[LIVE_STATE_BIT]      = lin_one_state_in;                  // RULE3
    lin_one_live[LIVE_WAKE_EN_BIT]    = lin_one_wake_receiver_enable_in;   // RULE3
    lin_two_live                      = '0;
    lin_two_live[LIVE_STATE_BIT]      = lin_two_state_in;                  // RULE4
    lin_two_live[LIVE_WAKE_EN_BIT]    = lin_two_wake_receiver_enable_in;   // RULE4
  end

  // Live bytes come straight from the inputs and no clear ever reaches them.
  assign next_resp = (sel == SEL_REG_LO)     ? reg_lo_byte :
                     (sel == SEL_REG_HI)     ? reg_hi_byte :
                     (sel == SEL_LIN1_FLAGS) ? {1'b0, lin_one_flags} :      // RULE1
                     (sel == SEL_LIN2_FLAGS) ? {1'b0, lin_two_flags} :      // RULE2
                     (sel == SEL_LIN1_LIVE)  ? lin_one_live :               // RULE18
                     (sel == SEL_LIN2_LIVE)  ? lin_two_live : RESP_UNMAPPED;

  // The flag value is captured in the same edge that clears it, so the host sees the fault.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      resp_valid_out <= 1'b0;
      resp_data_out  <= RESP_UNMAPPED;
    end
    else
    begin
      resp_valid_out <= cmd_valid_in;
      resp_data_out  <= next_resp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_lin_one_layout: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE1
    cmd_valid_in && cmd_in == CMD_LIN1_FLAGS
    |=> resp_valid_out && resp_data_out == {1'b0, $past(lin_one_flags)})
    else $error("first LIN flag byte wrong");

  chk_lin_two_layout: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE2
    cmd_valid_in && cmd_in == CMD_LIN2_FLAGS
    |=> resp_data_out[7] == 1'b0 && resp_data_out[6:0] == $past(lin_two_flags))
    else $error("second LIN flag byte wrong");

  chk_lin_one_live: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE3
    cmd_valid_in && cmd_in == CMD_LIN1_LIVE
    |=> resp_data_out == {$past(lin_one_state_in), $past(lin_one_wake_receiver_enable_in),
                          6'h00})
    else $error("first LIN live byte wrong");

  chk_lin_two_live: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE4
    cmd_valid_in && cmd_in == CMD_LIN2_LIVE
    |=> resp_data_out == {$past(lin_two_state_in), $past(lin_two_wake_receiver_enable_in),
                          6'h00})
    else $error("second LIN live byte wrong");

  chk_aux_overload_filter: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE5
    $rose(filt_flag[F_AUX_OVERLOAD])
    |-> $past(supply_cond_in.aux_overcurrent, 1) && $past(supply_cond_in.aux_overcurrent, 2))
    else $error("aux overload flag set without held fault");

  chk_aux_under_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE6
    filt_flag[F_AUX_UNDER] && supply_cond_in.aux_low && clr_reg_lo |=> filt_flag[F_AUX_UNDER])
    else $error("aux under flag cleared while fault present");

  chk_bus_hot_set: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE7
    supply_cond_in.bus_overtemp |=> dir_flag[D_BUS_HOT])
    else $error("bus supply hot flag not set");

  chk_main_mode_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE12
    $rose(filt_flag[F_MAIN_OVLD]) |-> $past(normal_mode_in))
    else $error("main overload flag set outside normal mode");

  chk_reset_short: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE15
    $rose(dir_flag[D_RESET_SHORT]) |-> $past(reset_pin_n_in, 1) && !$past(reset_pin_n_in, 2))
    else $error("short reset flag set without a pulse end");

  chk_batt_fail_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RULE16
    dir_flag[D_BATT_FAIL] && clr_reg_hi && !supply_cond_in.battery_below_fail
    |=> !dir_flag[D_BATT_FAIL])
    else $error("battery fail flag not cleared by read");

endmodule

// ===== host_model.sv
// Host side of the flag store: issues one read command and collects the answer.
// Assumes the device registers its answer on the same edge that takes the command.
`timescale 1ns/1ns

module host_model
(
  // Clock
  input  wire logic        ref_clk_in,
  // Device answer
  input  wire logic        resp_valid_in,
  input  wire logic [7:0]  resp_data_in,
  // Command to device
  output logic             cmd_valid_out,
  output logic [15:0]      cmd_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_out       = 16'h0000;
  end

  // Between requests the word is inverted so a stale command never looks valid.
  task automatic read_cmd(input logic [15:0] c, output logic [7:0] d, output logic v);
    @(posedge ref_clk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_out       = c;
    @(posedge ref_clk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_out       = ~c;
    v             = resp_valid_in;
    d             = resp_data_in;
  endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the fault flag store, driving reads through the host model.
// Assumes short filter and reset-pulse counts so the whole run stays brief.
`timescale 1ns/1ns

module tb_top;
  import flag_pkg::*;
  localparam int FILT = 4;
  localparam int SHRT = 16;

  logic         ref_clk_in;
  logic         rst_in;
  supply_cond_t sup;
  logic         normal_mode;
  logic         lp_on;
  logic         pin_n;
  lin_cond_t    lin_a;
  lin_cond_t    lin_b;
  logic [3:0]   live;
  logic         cmd_valid;
  logic [15:0]  cmd;
  logic         resp_valid;
  logic [7:0]   resp_data;
  logic [7:0]   d;
  logic         v;
  logic [6:0]   ra;
  logic [6:0]   rb;
  logic [15:0]  c;
  int           err_count;
  int           check_count;
  int           cycles;
  int           seed;
  logic [15:0]  cmd_list [7] = '{CMD_REG_FLAGS_LO, CMD_REG_FLAGS_HI, CMD_LIN1_FLAGS,
                                 CMD_LIN2_FLAGS, CMD_LIN1_LIVE, CMD_LIN2_LIVE, 16'h1234};

  supply_and_lin_fault_flags #(.FILTER_CYCLES_P(FILT), .SHORT_RST_CYCLES_P(SHRT)) u_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .supply_cond_in(sup),
    .normal_mode_in(normal_mode), .lowpower_vdd_on_in(lp_on), .reset_pin_n_in(pin_n),
    .lin_one_cond_in(lin_a), .lin_two_cond_in(lin_b), .lin_one_state_in(live[3]),
    .lin_one_wake_receiver_enable_in(live[2]), .lin_two_state_in(live[1]),
    .lin_two_wake_receiver_enable_in(live[0]), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .resp_valid_out(resp_valid), .resp_data_out(resp_data));

  host_model u_host (
    .ref_clk_in(ref_clk_in), .resp_valid_in(resp_valid), .resp_data_in(resp_data),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // The ceiling is dozens of times the few hundred cycles the tests need.
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic rd(input logic [15:0] cw, input logic [7:0] exp);
    u_host.read_cmd(cw, d, v);
    check_byte({7'h00, v}, 8'h01);
    check_byte(d, exp);
  endtask

  task automatic pulse(input int i, input int n);
    sup = supply_cond_t'(11'h001 << i);
    cyc(n);
    sup = '0;
  endtask

  function automatic logic [7:0] exp_mask(input int i);
    if (i == 2)
      return 8'h10;
    if (i < 2)
      return 8'(i + 1);
    return 8'(1 << (i - 3));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 31;
    cycles = 0;
    err_count = 0;
    check_count = 0;
    rst_in = 1'b1;
    sup = '0;
    normal_mode = 1'b1;
    lp_on = 1'b1;
    pin_n = 1'b1;
    lin_a = '0;
    lin_b = '0;
    live = 4'h0;
    cyc(12);
    rst_in = 1'b0;
    foreach (cmd_list[k])
      rd(cmd_list[k], 8'h00);
    $display("test reset_values done");

    for (int k = 0; k < 8; k++)
    begin
      ra = (k == 0) ? 7'h7F : 7'($random(seed));
      rb = (k == 0) ? 7'h7F : 7'($random(seed));
      lin_a = lin_cond_t'(ra);
      lin_b = lin_cond_t'(rb);
      cyc(1);
      lin_a = '0;
      lin_b = '0;
      rd(CMD_LIN1_FLAGS, {1'b0, ra});
      rd(CMD_LIN2_FLAGS, {1'b0, rb});
      rd(CMD_LIN1_FLAGS, 8'h00);
      rd(CMD_LIN2_FLAGS, 8'h00);
    end
    $display("test lin_flags done");

    lin_a = lin_cond_t'(7'h7F);
    cyc(1);
    rd(CMD_LIN1_FLAGS, 8'h7F);
    rd(CMD_LIN1_FLAGS, 8'h7F);
    lin_a = '0;
    rd(16'h1234, 8'h00);
    rd(CMD_LIN1_FLAGS, 8'h7F);
    rd(CMD_LIN1_FLAGS, 8'h00);
    $display("test read_during_fault done");

    for (int k = 0; k < 6; k++)
    begin
      live = (k < 2) ? {4{k[0]}} : 4'($random(seed));
      cyc(1);
      repeat (2)
      begin
        rd(CMD_LIN1_LIVE, {live[3:2], 6'h00});
        rd(CMD_LIN2_LIVE, {live[1:0], 6'h00});
      end
    end
    $display("test live_status done");

    // Filtered slots get a pulse one edge short of the filter before the real one.
    for (int i = 0; i < 11; i++)
    begin
      c = (i < 3) ? CMD_REG_FLAGS_HI : CMD_REG_FLAGS_LO;
      if (11'h6F9 & (11'h001 << i))
      begin
        pulse(i, FILT);
        rd(c, 8'h00);
        pulse(i, FILT + 1);
      end
      else
        pulse(i, 1);
      rd(c, exp_mask(i));
      rd(c, 8'h00);
    end
    // A read while the fault stands, or after leaving the mode, must keep the flag.
    sup = supply_cond_t'(11'h408);
    cyc(FILT + 1);
    rd(CMD_REG_FLAGS_LO, 8'h81);
    normal_mode = 1'b0;
    rd(CMD_REG_FLAGS_LO, 8'h81);
    sup = '0;
    rd(CMD_REG_FLAGS_LO, 8'h81);
    rd(CMD_REG_FLAGS_LO, 8'h00);
    lp_on = 1'b0;
    pulse(3, FILT + 4);
    pulse(0, FILT + 4);
    rd(CMD_REG_FLAGS_LO, 8'h00);
    rd(CMD_REG_FLAGS_HI, 8'h00);
    $display("test supply_flags done");

    pin_n = 1'b0;
    cyc(3);
    pin_n = 1'b1;
    cyc(2);
    rd(CMD_REG_FLAGS_HI, 8'h04);
    rd(CMD_REG_FLAGS_HI, 8'h00);
    pin_n = 1'b0;
    cyc(SHRT + 4);
    pin_n = 1'b1;
    cyc(2);
    rd(CMD_REG_FLAGS_HI, 8'h00);
    $display("test reset_pulse done");
    finish_test();
  end
endmodule
